// ==== src/bhrp_consts.svh ====
// register offsets, field positions and reset values of the host port
`ifndef BHRP_CONSTS_SVH
`define BHRP_CONSTS_SVH
`define BHRP_OFS_SEED3      8'h00
`define BHRP_OFS_SEED2      8'h01
`define BHRP_OFS_SEED1      8'h02
`define BHRP_OFS_SEED0      8'h03
`define BHRP_OFS_LENGTH     8'h04
`define BHRP_OFS_TAP        8'h05
`define BHRP_OFS_CONTROL    8'h06
`define BHRP_OFS_ERRINS     8'h07
`define BHRP_OFS_BITCNT3    8'h08
`define BHRP_OFS_BITCNT2    8'h09
`define BHRP_OFS_BITCNT1    8'h0a
`define BHRP_OFS_BITCNT0    8'h0b
`define BHRP_OFS_ERRCNT3    8'h0c
`define BHRP_OFS_ERRCNT2    8'h0d
`define BHRP_OFS_ERRCNT1    8'h0e
`define BHRP_OFS_ERRCNT0    8'h0f
`define BHRP_OFS_RXPAT3     8'h10
`define BHRP_OFS_RXPAT2     8'h11
`define BHRP_OFS_RXPAT1     8'h12
`define BHRP_OFS_RXPAT0     8'h13
`define BHRP_OFS_STATUS     8'h14
`define BHRP_OFS_INTMASK    8'h15
`define BHRP_OFS_TEST       8'h1c
`define BHRP_FLD_LEN_MSB    4
`define BHRP_FLD_TAP_MSB    4
`define BHRP_RST_BYTE       8'h00
`define BHRP_RST_WORD       32'h0000_0000
`define BHRP_EDGE_ADDR      0
`define BHRP_EDGE_TXCLK     1
`define BHRP_EDGE_RXCLK     2
`define BHRP_EDGE_TXLOAD    3
`define BHRP_EDGE_CNTLOAD   4
`define BHRP_EDGE_RXLOAD    5
`define BHRP_EDGE_COUNT     6
`endif

// ==== src/bhrp_pkg.sv ====
// types shared by the bert host register port
package bhrp_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b11
  } bhrp_bus_state_type;

  typedef struct packed {
    logic transmitLoad;
    logic zeroSuppress;
    logic pseudoRandom;
    logic countLoad;
    logic receiveLoad;
    logic syncEnable;
    logic resync;
    logic loopback;
  } bhrp_ctrl_type;

  typedef struct packed {
    logic [31:0]   seed;
    logic [4:0]    lengthField;
    logic [4:0]    tapA;
    logic [4:0]    tapField;
    bhrp_ctrl_type ctrl;
    logic [7:0]    errorInsert;
    logic [7:0]    intMask;
    logic [7:0]    factoryTest;
  } bhrp_config_type;

  typedef struct packed {
    bhrp_bus_state_type busState;
    logic [7:0]    addr;
    logic [7:0]    wrData;
    logic [7:0]    rdData;
    logic          rdOe;
    logic [31:0]   seed;
    logic [7:0]    lengthReg;
    logic [7:0]    tapReg;
    bhrp_ctrl_type ctrl;
    logic [7:0]    errorInsert;
    logic [7:0]    intMask;
    logic [7:0]    factoryTest;
    logic [31:0]   bitCount;
    logic [31:0]   errCount;
    logic [31:0]   bitShadow;
    logic [31:0]   errShadow;
    logic [31:0]   rxShift;
    logic [31:0]   rxShadow;
    logic          pendTx;
    logic          pendCnt;
    logic          pendRx;
    logic          genLoad;
  } bhrp_state_type;
endpackage

// ==== src/bhrp_edge_detect.sv ====
// rising and falling edge detector for a group of synchronous levels
`timescale 1ns/1ps
`default_nettype none
module bhrp_edge_detect #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  if (WIDTH < 1) begin : g_chk
    $error("edge detector needs at least one bit");
  end

  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule
`default_nettype wire

// ==== src/bhrp_byte_pick.sv ====
// picks one byte of a word, byte 3 at the lowest sub-address
`timescale 1ns/1ps
`default_nettype none
module bhrp_byte_pick (
  input  wire logic [31:0] word,
  input  wire logic [1:0]  sel,
  output logic      [7:0]  pick
);
  always_comb begin
    case (sel)
      2'h0: pick = word[31:24];
      2'h1: pick = word[23:16];
      2'h2: pick = word[15:8];
      2'h3: pick = word[7:0];
      default: pick = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// ==== src/bhrp_host_port.sv ====
// host register bank and multiplexed control port of the bit error tester
`timescale 1ns/1ps
`default_nettype none
`include "bhrp_consts.svh"
module bhrp_host_port #(
  parameter int COUNT_WIDTH = 32
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     busTypeStrap,
  input  wire logic                     chipSelect_n,
  input  wire logic                     rdOrDs,
  input  wire logic                     wrOrRw,
  input  wire logic                     addressLatchStrobe,
  input  wire logic [7:0]               adIn,
  output logic      [7:0]               adOut,
  output logic                          adOe,
  input  wire logic                     transmitLineClock,
  input  wire logic                     receiveLineClock,
  input  wire logic                     receiveDisable,
  input  wire logic                     receiveData,
  input  wire logic                     receiveBitError,
  input  wire logic                     transmitLoadPin,
  input  wire logic                     countLoadPin,
  input  wire logic                     receiveLoadPin,
  input  wire logic [7:0]               statusIn,
  output bhrp_pkg::bhrp_config_type     cfg,
  output logic                          generatorLoad
);
  bhrp_pkg::bhrp_state_type st_q;
  bhrp_pkg::bhrp_state_type st_d;
  logic [`BHRP_EDGE_COUNT-1:0] lvl;
  logic [`BHRP_EDGE_COUNT-1:0] rise;
  logic [`BHRP_EDGE_COUNT-1:0] fall;
  logic [3*32-1:0]             groups;
  logic [3*8-1:0]              picked;
  logic                        readActive;
  logic                        writeActive;
  logic                        txEdge;
  logic                        rxEdge;
  logic                        rxCount;
  logic [7:0]                  readByte;

  if (COUNT_WIDTH != 32) begin : g_chk
    $error("counters must be 32 bits to fill four bytes");
  end

  always_comb begin
    if (busTypeStrap) begin
      readActive  = !chipSelect_n && rdOrDs && wrOrRw;
      writeActive = !chipSelect_n && rdOrDs && !wrOrRw;
    end else begin
      readActive  = !chipSelect_n && !rdOrDs;
      writeActive = !chipSelect_n && !wrOrRw;
    end
  end

  // load bits ORed with their pins
  assign lvl[`BHRP_EDGE_ADDR]    = addressLatchStrobe;
  assign lvl[`BHRP_EDGE_TXCLK]   = transmitLineClock;
  assign lvl[`BHRP_EDGE_RXCLK]   = receiveLineClock;
  assign lvl[`BHRP_EDGE_TXLOAD]  = transmitLoadPin | st_q.ctrl.transmitLoad;
  assign lvl[`BHRP_EDGE_CNTLOAD] = countLoadPin | st_q.ctrl.countLoad;
  assign lvl[`BHRP_EDGE_RXLOAD]  = receiveLoadPin | st_q.ctrl.receiveLoad;

  bhrp_edge_detect #(
    .WIDTH (`BHRP_EDGE_COUNT)
  ) u_edges (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .level   (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  assign txEdge  = rise[`BHRP_EDGE_TXCLK];
  assign rxEdge  = rise[`BHRP_EDGE_RXCLK];
  assign rxCount = rxEdge && !receiveDisable;

  // msb of each group in byte 3
  assign groups = {st_q.rxShadow, st_q.errShadow, st_q.bitShadow};

  for (genvar g = 0; g < 3; g++) begin : g_pick
    bhrp_byte_pick u_pick (
      .word (groups[g*32 +: 32]),
      .sel  (st_q.addr[1:0]),
      .pick (picked[g*8 +: 8])
    );
  end

  always_comb begin
    case (st_q.addr)
      `BHRP_OFS_SEED3:   readByte = st_q.seed[31:24];
      `BHRP_OFS_SEED2:   readByte = st_q.seed[23:16];
      `BHRP_OFS_SEED1:   readByte = st_q.seed[15:8];
      `BHRP_OFS_SEED0:   readByte = st_q.seed[7:0];
      `BHRP_OFS_LENGTH:  readByte = st_q.lengthReg;
      `BHRP_OFS_TAP:     readByte = st_q.tapReg;
      `BHRP_OFS_CONTROL: readByte = st_q.ctrl;
      `BHRP_OFS_ERRINS:  readByte = st_q.errorInsert;
      `BHRP_OFS_BITCNT3, `BHRP_OFS_BITCNT2,
      `BHRP_OFS_BITCNT1, `BHRP_OFS_BITCNT0: readByte = picked[7:0];
      `BHRP_OFS_ERRCNT3, `BHRP_OFS_ERRCNT2,
      `BHRP_OFS_ERRCNT1, `BHRP_OFS_ERRCNT0: readByte = picked[15:8];
      `BHRP_OFS_RXPAT3, `BHRP_OFS_RXPAT2,
      `BHRP_OFS_RXPAT1, `BHRP_OFS_RXPAT0: readByte = picked[23:16];
      `BHRP_OFS_STATUS:  readByte = statusIn;
      `BHRP_OFS_INTMASK: readByte = st_q.intMask;
      `BHRP_OFS_TEST:    readByte = st_q.factoryTest;
      default:           readByte = 8'h00;
    endcase
  end

  always_comb begin
    st_d         = st_q;
    st_d.genLoad = 1'b0;
    // address taken as the latch strobe falls
    if (fall[`BHRP_EDGE_ADDR]) begin
      st_d.addr = adIn;
    end
    // data phase follows the address phase
    case (st_q.busState)
      bhrp_pkg::BUS_IDLE: begin
        if (readActive) begin
          // byte driven while the read pulse lasts
          st_d.busState = bhrp_pkg::BUS_READ;
          st_d.rdData   = readByte;
          st_d.rdOe     = 1'b1;
        end else if (writeActive) begin
          st_d.busState = bhrp_pkg::BUS_WRITE;
          st_d.wrData   = adIn;
        end
      end
      bhrp_pkg::BUS_READ: begin
        // release when the read pulse ends
        if (!readActive) begin
          st_d.busState = bhrp_pkg::BUS_IDLE;
          st_d.rdOe     = 1'b0;
        end
      end
      bhrp_pkg::BUS_WRITE: begin
        if (writeActive) begin
          st_d.wrData = adIn;
        end else begin
          st_d.busState = bhrp_pkg::BUS_IDLE;
          // seed byte 3 holds bits 31..24
          case (st_q.addr)
            `BHRP_OFS_SEED3:   st_d.seed[31:24] = st_q.wrData;
            `BHRP_OFS_SEED2:   st_d.seed[23:16] = st_q.wrData;
            `BHRP_OFS_SEED1:   st_d.seed[15:8]  = st_q.wrData;
            `BHRP_OFS_SEED0:   st_d.seed[7:0]   = st_q.wrData;
            `BHRP_OFS_LENGTH:  st_d.lengthReg   = st_q.wrData;
            `BHRP_OFS_TAP:     st_d.tapReg      = st_q.wrData;
            `BHRP_OFS_CONTROL: st_d.ctrl        = st_q.wrData;
            `BHRP_OFS_ERRINS:  st_d.errorInsert = st_q.wrData;
            `BHRP_OFS_INTMASK: st_d.intMask     = st_q.wrData;
            `BHRP_OFS_TEST:    st_d.factoryTest = st_q.wrData;
            default:           st_d.seed        = st_q.seed;
          endcase
        end
      end
      default: begin
        st_d.busState = bhrp_pkg::BUS_IDLE;
        st_d.rdOe     = 1'b0;
      end
    endcase

    // loads wait for the line clock edge
    st_d.pendTx = (st_q.pendTx && !txEdge) || rise[`BHRP_EDGE_TXLOAD];
    st_d.pendCnt = (st_q.pendCnt && !rxEdge) || rise[`BHRP_EDGE_CNTLOAD];
    st_d.pendRx = (st_q.pendRx && !rxEdge) || rise[`BHRP_EDGE_RXLOAD];

    // generator loaded from the seed bytes
    if (st_q.pendTx && txEdge) begin
      st_d.genLoad = 1'b1;
    end

    if (rxCount) begin
      st_d.rxShift  = {st_q.rxShift[30:0], receiveData};
      st_d.bitCount = st_q.bitCount + 32'h0000_0001;
      if (receiveBitError) begin
        st_d.errCount = st_q.errCount + 32'h0000_0001;
      end
    end

    // last 32 received bits copied out
    if (st_q.pendRx && rxEdge) begin
      st_d.rxShadow = st_q.rxShift;
    end

    if (st_q.pendCnt && rxEdge) begin
      st_d.bitShadow = st_q.bitCount;
      st_d.errShadow = st_q.errCount;
      st_d.bitCount  = {31'h0000_0000, rxCount};
      st_d.errCount  = {31'h0000_0000, rxCount && receiveBitError};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q             <= '0;
      st_q.busState    <= bhrp_pkg::BUS_IDLE;
      st_q.seed        <= `BHRP_RST_WORD;
      st_q.lengthReg   <= `BHRP_RST_BYTE;
      st_q.tapReg      <= `BHRP_RST_BYTE;
      st_q.ctrl        <= `BHRP_RST_BYTE;
      st_q.errorInsert <= `BHRP_RST_BYTE;
      st_q.intMask     <= `BHRP_RST_BYTE;
      st_q.factoryTest <= `BHRP_RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  assign adOut         = st_q.rdData;
  assign adOe          = st_q.rdOe;
  assign generatorLoad = st_q.genLoad;

  always_comb begin
    cfg             = '0;
    cfg.seed        = st_q.seed;
    cfg.lengthField = st_q.lengthReg[`BHRP_FLD_LEN_MSB:0];
    cfg.tapA        = st_q.lengthReg[`BHRP_FLD_LEN_MSB:0];
    cfg.tapField    = st_q.tapReg[`BHRP_FLD_TAP_MSB:0];
    cfg.ctrl        = st_q.ctrl;
    cfg.errorInsert = st_q.errorInsert;
    cfg.intMask     = st_q.intMask;
    cfg.factoryTest = st_q.factoryTest;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence read_start;
    st_q.busState == bhrp_pkg::BUS_IDLE && readActive;
  endsequence

  sequence write_end;
    st_q.busState == bhrp_pkg::BUS_WRITE && !writeActive;
  endsequence

  addr_capture_a: assert property (
    $fell(addressLatchStrobe) |=> st_q.addr == $past(adIn))
    else $error("address not captured at latch strobe fall");

  strobe_read_a: assert property (
    (read_start and (busTypeStrap && rdOrDs && wrOrRw)) |=> adOe)
    else $error("data strobe read did not drive the bus");

  split_write_a: assert property (
    (!busTypeStrap && st_q.busState == bhrp_pkg::BUS_IDLE
     && !chipSelect_n && !wrOrRw && rdOrDs)
    |=> st_q.busState == bhrp_pkg::BUS_WRITE && !adOe)
    else $error("write strobe did not start a write");

  read_drive_a: assert property (
    read_start |=> adOe && adOut == $past(readByte))
    else $error("read byte not driven");

  read_release_a: assert property (
    (st_q.busState == bhrp_pkg::BUS_READ && !readActive) |=> !adOe)
    else $error("bus not released at end of read");

  bit_count_a: assert property (
    (read_start and (st_q.addr == `BHRP_OFS_BITCNT3))
    |=> adOut == st_q.bitShadow[31:24])
    else $error("bit count byte 3 misplaced");

  error_count_a: assert property (
    (read_start and (st_q.addr == `BHRP_OFS_ERRCNT0))
    |=> adOut == st_q.errShadow[7:0])
    else $error("error count byte 0 misplaced");

  rx_pattern_a: assert property (
    (read_start and (st_q.addr == `BHRP_OFS_RXPAT2))
    |=> adOut == st_q.rxShadow[23:16])
    else $error("received pattern byte 2 misplaced");

  seed_write_a: assert property (
    (write_end and (st_q.addr == `BHRP_OFS_SEED3))
    |=> cfg.seed[31:24] == $past(st_q.wrData))
    else $error("seed byte 3 not written to bits 31..24");

  tap_follow_a: assert property (
    (write_end and (st_q.addr == `BHRP_OFS_LENGTH))
    |=> cfg.tapA == $past(st_q.wrData[4:0])
        && cfg.lengthField == cfg.tapA)
    else $error("first tap does not follow the length");

  tx_load_a: assert property (
    (st_q.pendTx && txEdge) |=> generatorLoad ##1 !generatorLoad)
    else $error("generator load pulse missing");

  count_load_a: assert property (
    (st_q.pendCnt && rxEdge)
    |=> st_q.bitShadow == $past(st_q.bitCount)
        && st_q.bitCount <= 32'h0000_0001)
    else $error("count load did not copy and clear");

  rx_load_a: assert property (
    (st_q.pendRx && rxEdge) |=> st_q.rxShadow == $past(st_q.rxShift))
    else $error("received pattern not copied");

  load_wait_a: assert property (
    (rise[`BHRP_EDGE_CNTLOAD] && !rxEdge) |=> st_q.pendCnt)
    else $error("count load not held for the line clock");
endmodule
`default_nettype wire

// ==== tb/bhrp_host_model.sv ====
// host microcontroller model on the multiplexed control port
`timescale 1ns/1ps
`default_nettype none
module bhrp_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] adOut,
  input  wire logic       adOe,
  output logic            busTypeStrap,
  output logic            chipSelect_n,
  output logic            rdOrDs,
  output logic            wrOrRw,
  output logic            addressLatchStrobe,
  output logic      [7:0] adBus
);
  logic       drv;
  logic [7:0] drvVal;
  logic [7:0] lastVal;
  // released bus has no pull, so it shows the inverse of its last level
  assign adBus = adOe ? adOut : (drv ? drvVal : ~lastVal);
  always @(posedge clk_sys) begin
    if (adOe || drv) lastVal <= adBus;
  end
  initial begin
    drv = 1'b0;
    drvVal = 8'h00;
    lastVal = 8'h00;
    busTypeStrap = 1'b0;
    chipSelect_n = 1'b1;
    rdOrDs = 1'b1;
    wrOrRw = 1'b1;
    addressLatchStrobe = 1'b0;
  end
  task automatic setStrap(input logic s);
    @(posedge clk_sys);
    busTypeStrap <= s;
    rdOrDs       <= ~s;
  endtask
  // address first, held past latch fall
  task automatic addrPhase(input logic [7:0] a);
    @(posedge clk_sys);
    drv                <= 1'b1;
    drvVal             <= a;
    addressLatchStrobe <= 1'b1;
    @(posedge clk_sys);
    addressLatchStrobe <= 1'b0;
  endtask
  task automatic endStrobe();
    chipSelect_n <= 1'b1;
    wrOrRw       <= 1'b1;
    rdOrDs       <= ~busTypeStrap;
  endtask
  // write data held to strobe end
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    addrPhase(a);
    @(posedge clk_sys);
    drvVal       <= d;
    chipSelect_n <= 1'b0;
    wrOrRw       <= 1'b0;
    rdOrDs       <= 1'b1;
    repeat (2) @(posedge clk_sys);
    endStrobe();
    @(posedge clk_sys);
    drv <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic readReg(input logic [7:0] a, output logic [7:0] d,
                         output logic oe, output logic held);
    int n;
    addrPhase(a);
    @(posedge clk_sys);
    drv          <= 1'b0;
    chipSelect_n <= 1'b0;
    rdOrDs       <= busTypeStrap;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (adOe !== 1'b1 && n < 8);
    @(posedge clk_sys);
    d  = adBus;
    oe = adOe;
    endStrobe();
    repeat (3) @(posedge clk_sys);
    held = adOe;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_bert_host_register_port.sv ====
// self-checking bench of the bert host register port
`timescale 1ns/1ps
`default_nettype none
`include "bhrp_consts.svh"
module test_bert_host_register_port;
  localparam logic [31:0] PAL = 32'h0f33ccf0;
  logic       clk_sys, reset_n, transmitLineClock, receiveLineClock;
  logic       receiveDisable, receiveData, receiveBitError;
  logic       transmitLoadPin, countLoadPin, receiveLoadPin;
  logic [7:0] statusIn;
  wire logic  busTypeStrap, chipSelect_n, rdOrDs, wrOrRw;
  wire logic  addressLatchStrobe, adOe, generatorLoad;
  wire logic [7:0] adOut, adBus;
  bhrp_pkg::bhrp_config_type cfg;
  int         fails, checksDone, genPulses, expBits, expErrs;

  bhrp_host_port dut (.clk_sys, .reset_n, .busTypeStrap, .chipSelect_n,
    .rdOrDs, .wrOrRw, .addressLatchStrobe, .adIn(adBus), .adOut, .adOe,
    .transmitLineClock, .receiveLineClock, .receiveDisable, .receiveData,
    .receiveBitError, .transmitLoadPin, .countLoadPin, .receiveLoadPin,
    .statusIn, .cfg, .generatorLoad);
  bhrp_host_model host (.clk_sys, .adOut, .adOe, .busTypeStrap,
    .chipSelect_n, .rdOrDs, .wrOrRw, .addressLatchStrobe, .adBus);

  task automatic testDone();
    if (fails == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdByte(input logic [7:0] a, output logic [7:0] d);
    logic oe, held;
    host.readReg(a, d, oe, held);
    chk("read drive", 1, oe);
    chk("read release", 0, held);
  endtask
  task automatic chkWord(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rdByte(8'(a + i), b);
      chk(nm, e[31-8*i -: 8], b);
    end
  endtask
  task automatic rxBit(input logic d, input logic e, input logic dis);
    @(posedge clk_sys);
    receiveData     <= d;
    receiveBitError <= e;
    receiveDisable  <= dis;
    @(posedge clk_sys);
    receiveLineClock <= 1'b1;
    repeat (2) @(posedge clk_sys);
    receiveLineClock <= 1'b0;
    if (!dis) expBits++;
    if (!dis) expErrs += e;
  endtask
  task automatic txEdge();
    repeat (3) @(posedge clk_sys);
    transmitLineClock <= 1'b1;
    repeat (2) @(posedge clk_sys);
    transmitLineClock <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    testDone();
  end
  always @(posedge clk_sys) begin
    if (generatorLoad === 1'b1) genPulses++;
  end

  initial begin
    logic [7:0]  v, b;
    logic [7:0]  wr [9];
    logic [31:0] nb, ne;
    void'($urandom(32'hdb30));
    {reset_n, transmitLineClock, receiveLineClock, receiveDisable} = 4'h0;
    {receiveData, receiveBitError, transmitLoadPin} = 3'h0;
    {countLoadPin, receiveLoadPin} = 2'h0;
    statusIn = 8'($urandom);
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      rdByte(8'(a), b);
      chk("reset value", (a == 8'h14) ? statusIn : 8'h00, b);
    end
    host.writeReg(`BHRP_OFS_TEST, 8'h5a);
    chk("test register", 8'h5a, cfg.factoryTest);
    host.writeReg(`BHRP_OFS_TEST, 8'h00);
    chk("test register", 0, cfg.factoryTest);
    rdByte(`BHRP_OFS_TEST, b);
    chk("test register read", 0, b);
    for (int s = 0; s < 2; s++) begin
      host.setStrap(s[0]);
      for (int i = 0; i < 9; i++) begin
        v = 8'($urandom);
        if (i < 4 && s == 1) v = 8'hff;
        if (i == 4 || i == 5) v &= 8'h1f;
        if (i == 6) v &= 8'h67;
        wr[i] = v;
        host.writeReg((i == 8) ? `BHRP_OFS_INTMASK : 8'(i), v);
      end
      host.writeReg(`BHRP_OFS_BITCNT0, 8'($urandom));
      host.writeReg(8'h1f, 8'($urandom));
      for (int i = 0; i < 9; i++) begin
        rdByte((i == 8) ? `BHRP_OFS_INTMASK : 8'(i), b);
        chk("readback", wr[i], b);
      end
      rdByte(`BHRP_OFS_BITCNT0, b);
      chk("read-only byte", 0, b);
      rdByte(8'h1f, b);
      chk("unmapped byte", 0, b);
      chk("seed", {wr[0], wr[1], wr[2], wr[3]}, cfg.seed);
      chk("length", wr[4][4:0], cfg.lengthField);
      chk("tap a", wr[4][4:0], cfg.tapA);
      chk("tap b", wr[5][4:0], cfg.tapField);
      chk("control", wr[6], cfg.ctrl);
      chk("insert", wr[7], cfg.errorInsert);
      chk("mask", wr[8], cfg.intMask);
    end
    expBits = 0;
    expErrs = 0;
    repeat (20) rxBit(1'($urandom), 1'($urandom), 1'($urandom));
    for (int i = 31; i >= 0; i--) rxBit(PAL[i], 1'($urandom), 1'b0);
    @(posedge clk_sys);
    countLoadPin   <= 1'b1;
    receiveLoadPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    nb = expBits;
    ne = expErrs;
    rxBit(1'b1, 1'b0, 1'b0);
    expBits = 1;
    countLoadPin   <= 1'b0;
    receiveLoadPin <= 1'b0;
    chkWord("bit count", `BHRP_OFS_BITCNT3, nb);
    chkWord("error count", `BHRP_OFS_ERRCNT3, ne);
    chkWord("rx pattern", `BHRP_OFS_RXPAT3, PAL);
    expErrs = 0;
    repeat (5) rxBit(1'b0, 1'b1, 1'b0);
    host.writeReg(`BHRP_OFS_CONTROL, 8'h10);
    nb = expBits;
    ne = expErrs;
    rxBit(1'b0, 1'b0, 1'b0);
    repeat (3) rxBit(1'b1, 1'b1, 1'b0);
    chkWord("bit count", `BHRP_OFS_BITCNT3, nb);
    chkWord("error count", `BHRP_OFS_ERRCNT3, ne);
    host.writeReg(`BHRP_OFS_CONTROL, 8'h00);
    genPulses = 0;
    @(posedge clk_sys);
    transmitLoadPin <= 1'b1;
    txEdge();
    chk("generator load", 1, genPulses);
    transmitLoadPin <= 1'b0;
    host.writeReg(`BHRP_OFS_CONTROL, 8'h80);
    txEdge();
    chk("generator load", 2, genPulses);
    txEdge();
    chk("generator load", 2, genPulses);
    testDone();
  end
endmodule
`default_nettype wire
